// file: verilog/bsc_map.vh
// Function
// - decode skip-on-clear from top nibble 0110
// - skip-on-clear skips when selected bit is 0
// - taken skip flushes prefetch, executes nop instead
// - decode skip-on-set from top nibble 0111
// - skip-on-set skips when selected bit is 1
// - bit tests take one cycle, two if skipping
// - none of these instructions touch status flags
// - call pushes own pc plus one
// - call prefix 1001 loads literal into pc 7:0
// - call copies status 6:5 to pc 10:9, clears pc 8
// - call always takes two cycles, flushing prefetch
`ifndef BSC_MAP_VH
`define BSC_MAP_VH
// ----------------------------------------
// opcode fields
// ----------------------------------------
`define BSC_OP_SKIP_CLEAR 4'h6
`define BSC_OP_SKIP_SET 4'h7
`define BSC_OP_CALL 4'h9
`define BSC_OP_HI 11
`define BSC_OP_LO 8
`define BSC_BIT_HI 7
`define BSC_BIT_LO 5
`define BSC_REG_HI 4
`define BSC_REG_LO 0
`define BSC_LIT_HI 7
`define BSC_LIT_LO 0
`define BSC_PAGE_HI 6
`define BSC_PAGE_LO 5
// ----------------------------------------
// reset values
// ----------------------------------------
`define BSC_PC_RESET 11'h000
`endif

// file: verilog/bsc_exec.v
`timescale 1ns/1ps
`include "bsc_map.vh"
module bsc_exec (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // fetched instruction
  input wire instr_valid_i,
  input wire [11:0] instr_i,
  input wire [10:0] pc_i,
  // register file and status
  input wire [255:0] reg_file_i,
  input wire [7:0] status_i,
  // execution control
  output reg flush_o,
  output reg nop_slot_o,
  output reg push_o,
  output reg [10:0] push_addr_o,
  output reg pc_load_o,
  output reg [10:0] pc_next_o,
  output wire [7:0] status_o,
  output reg busy_o
);
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  // one-hot: decode window, or the bubble left by a flush
  localparam [1:0] ST_DECODE = 2'b01;
  localparam [1:0] ST_BUBBLE = 2'b10;

  // ----------------------------------------
  // field helpers
  // ----------------------------------------
  // register n sits at bits 8n+7..8n of the flat file
  function [7:0] reg_sel;
    input [255:0] rf;
    input [4:0] addr;
    begin
      reg_sel = rf[{addr, 3'h0} +: 8];
    end
  endfunction

  function [3:0] op_field;
    input [11:0] word;
    begin
      op_field = word[`BSC_OP_HI:`BSC_OP_LO];
    end
  endfunction

  function [2:0] bit_field;
    input [11:0] word;
    begin
      bit_field = word[`BSC_BIT_HI:`BSC_BIT_LO];
    end
  endfunction

  function [4:0] reg_field;
    input [11:0] word;
    begin
      reg_field = word[`BSC_REG_HI:`BSC_REG_LO];
    end
  endfunction

  function [7:0] lit_field;
    input [11:0] word;
    begin
      lit_field = word[`BSC_LIT_HI:`BSC_LIT_LO];
    end
  endfunction

  function is_op;
    input [3:0] op;
    input [3:0] code;
    begin
      is_op = (op == code);
    end
  endfunction

  function bit_of;
    input [7:0] val;
    input [2:0] idx;
    begin
      bit_of = val[idx];
    end
  endfunction

  function skip_taken;
    input clr_hit;
    input set_hit;
    input bit_val;
    begin
      skip_taken = (clr_hit && !bit_val) || (set_hit && bit_val);
    end
  endfunction

  // page bits come from status, bit 8 is forced low
  function [10:0] call_target;
    input [7:0] status;
    input [7:0] lit;
    begin
      call_target = {status[`BSC_PAGE_HI:`BSC_PAGE_LO], 1'b0, lit};
    end
  endfunction

  // wraps at the top of the 11-bit space, as the program counter does
  function [10:0] return_addr;
    input [10:0] pc;
    begin
      return_addr = pc + 11'h001;
    end
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  wire decode_en;
  wire [3:0] opcode;
  wire [2:0] bit_idx;
  wire [4:0] reg_idx;
  wire [7:0] lit_val;
  wire [7:0] reg_val;
  wire tested_bit;
  wire is_clr;
  wire is_set;
  wire is_call;
  wire skip;
  wire redirect;
  reg flush_d;
  reg nop_slot_d;
  reg push_d;
  reg pc_load_d;
  reg busy_d;
  reg [10:0] push_addr_d;
  reg [10:0] pc_next_d;

  // the slot after a skip or call is a bubble, so decode is held off there
  assign decode_en = instr_valid_i && state_q[0];
  assign opcode = op_field(instr_i);
  assign bit_idx = bit_field(instr_i);
  assign reg_idx = reg_field(instr_i);
  assign lit_val = lit_field(instr_i);
  assign reg_val = reg_sel(reg_file_i, reg_idx);
  assign tested_bit = bit_of(reg_val, bit_idx);
  // limitation: only these three opcodes are recognised, others pass silently
  assign is_clr = decode_en && is_op(opcode, `BSC_OP_SKIP_CLEAR);
  assign is_set = decode_en && is_op(opcode, `BSC_OP_SKIP_SET);
  assign is_call = decode_en && is_op(opcode, `BSC_OP_CALL);
  assign skip = skip_taken(is_clr, is_set, tested_bit);
  // a taken skip and a call both waste the prefetched slot
  assign redirect = skip || is_call;

  // status is passed through untouched by all three instructions
  assign status_o = status_i;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_d = ST_DECODE;
    case (state_q)
      ST_DECODE: begin
        if (redirect) begin
          state_d = ST_BUBBLE;
        end else begin
          state_d = ST_DECODE;
        end
      end
      ST_BUBBLE: begin
        // a bubble never chains: it decodes nothing, so it costs one cycle
        state_d = ST_DECODE;
      end
      default: begin
        state_d = ST_DECODE;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_q <= ST_DECODE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // next values of the control outputs
  // ----------------------------------------
  always @* begin
    flush_d = 1'b0;
    nop_slot_d = 1'b0;
    push_d = 1'b0;
    pc_load_d = 1'b0;
    busy_d = 1'b0;
    push_addr_d = push_addr_o;
    pc_next_d = pc_next_o;
    case (state_q)
      ST_DECODE: begin
        flush_d = redirect;
        nop_slot_d = skip;
        push_d = is_call;
        pc_load_d = is_call;
        busy_d = redirect;
        if (is_call) begin
          push_addr_d = return_addr(pc_i);
          pc_next_d = call_target(status_i, lit_val);
        end
      end
      ST_BUBBLE: begin
        // the bubble decodes nothing; the held targets stay for the fetch side
        busy_d = 1'b0;
      end
      default: begin
        busy_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // pulse registers
  // ----------------------------------------
  // every pulse lasts one cycle, so the fetch side never sees it twice
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= flush_d;
    end
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      nop_slot_o <= 1'b0;
    end else begin
      nop_slot_o <= nop_slot_d;
    end
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      push_o <= 1'b0;
    end else begin
      push_o <= push_d;
    end
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= pc_load_d;
    end
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= busy_d;
    end
  end

  // ----------------------------------------
  // target registers
  // ----------------------------------------
  // targets reset to the start address so a stray load is harmless
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      push_addr_o <= `BSC_PC_RESET;
    end else begin
      push_addr_o <= push_addr_d;
    end
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pc_next_o <= `BSC_PC_RESET;
    end else begin
      pc_next_o <= pc_next_d;
    end
  end
endmodule // bsc_exec

// file: bench/bsc_exec_asserts.sv
`timescale 1ns/1ps
module bsc_chk(input wire core_clk_i,resetn_i,instr_valid_i,flush_o,nop_slot_o,push_o,
  pc_load_o,busy_o,input wire [11:0] instr_i,input wire [10:0] pc_i,push_addr_o,pc_next_o,
  input wire [255:0] reg_file_i,input wire [7:0] status_i,status_o);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // decode only what the core may take; the bubble cycle is never a request
  wire [11:0] n=instr_i;
  wire g=instr_valid_i&!busy_o;
  wire c=g&n[11:8]==4'h9;
  wire t=g&n[11:9]==3'h3;
  wire s=t&reg_file_i[{n[4:0],n[7:5]}]==n[8];
  sequence s_two; busy_o ##1 !busy_o; endsequence
  a_skip_take: assert property(s|=>flush_o&nop_slot_o) else $error("skip");
  a_no_skip: assert property(t&!s|=>!busy_o) else $error("noskip");
  a_two_cyc: assert property(s|c|=>s_two) else $error("cycles");
  a_push_addr: assert property(c|=>push_o&push_addr_o==$past(pc_i)+11'h1) else $error("push");
  a_call_pc: assert property(c|=>pc_load_o&pc_next_o=={$past(status_i[6:5]),1'b0,
    $past(n[7:0])}) else $error("pc");
  a_flush_why: assert property(flush_o|->$past(s|c)) else $error("flush");
  a_nop_why: assert property(nop_slot_o|->$past(s)&!push_o) else $error("nop");
  a_status_keep: assert property(status_o==status_i) else $error("status");
endmodule // bsc_chk
bind bsc_exec bsc_chk u_chk(.*);

// file: bench/bsc_fetch.sv
`timescale 1ns/1ps
// fetch side: steps by one, jumps on a load; no stack, so returns are not modelled
module bsc_fetch(input wire core_clk_i,ld_i,input wire [10:0] nx_i,output logic [10:0] pc_o=0);
  always @(posedge core_clk_i) pc_o<=ld_i?nx_i:pc_o+11'h1;
endmodule // bsc_fetch

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk_i=0,resetn_i=0,v=0,s,c;
  logic [11:0] ins=0;logic [255:0] rf=0;logic [7:0] st=0,k;logic [10:0] p;
  logic [10:0] pa_e=0,pn_e=0;
  wire f,o,u,l,b;wire [10:0] pa,pn,pc;wire [7:0] so;int err_count=0,n_tests=0;
  always #2.5 core_clk_i=~core_clk_i;
  bsc_exec u_dut(.core_clk_i,.resetn_i,.instr_valid_i(v),.instr_i(ins),.pc_i(pc),.reg_file_i(rf),
    .status_i(st),.flush_o(f),.nop_slot_o(o),.push_o(u),.push_addr_o(pa),.pc_load_o(l),
    .pc_next_o(pn),.status_o(so),.busy_o(b));
  bsc_fetch u_fetch(.core_clk_i,.ld_i(l),.nx_i(pn),.pc_o(pc));
  task chk(string n,logic [31:0] e,a);n_tests++;
    if(e!==a) begin err_count++;$display("[ERR] %s exp %h got %h",n,e,a);end endtask
  task finish_test;$display("checks %0d errors %0d",n_tests,err_count);
    if(err_count==0&&n_tests>0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;endtask
  initial begin #9000 err_count++;finish_test;end
  function logic skip_exp(logic [11:0] i,logic [255:0] r);
    skip_exp=i[11:9]==3'h3&&r[{i[4:0],i[7:5]}]==i[8];endfunction
  // one instruction, then its bubble; after a skip or call it is offered again and must be ignored
  task run_one(logic [11:0] i,logic [255:0] r,logic [7:0] t);
    @(posedge core_clk_i);v<=1;ins<=i;rf<=r;st<=t;
    #1 s=skip_exp(i,r);c=i[11:8]==4'h9;p=pc+11'h1;k=i[7:0];
    @(posedge core_clk_i) v<=s|c;
    #1 chk("ctl",{f,o,u,l,b},{s|c,s,c,c,s|c});
    chk("status",so,t);
    if(c) begin pa_e=p;pn_e={t[6:5],1'b0,k};end
    chk("call",{pa,pn},{pa_e,pn_e});
    @(posedge core_clk_i) v<=0;
    #1 chk("bubble",{f,o,u,l,b},0);
  endtask
  // corners first, then opcodes 6..9 at random: both skips, the call and one that stays silent
  initial begin void'($urandom(32'h071035ac));repeat(5) @(posedge core_clk_i);resetn_i<=1;
    run_one(12'h6ff,{256{1'b1}},8'h00);
    run_one(12'h6ff,256'h0,8'hff);
    run_one(12'h7e0,{248'h0,8'h80},8'h9f);
    run_one(12'h9ff,256'h0,8'h60);
    run_one(12'h900,256'h0,8'h9f);
    run_one(12'h5a5,256'h0,8'h00);
    repeat(300) run_one(12'($urandom%1024+32'h600),{8{$urandom}},8'($urandom));
    $display("done");finish_test;end
endmodule // tb
